// File: rtl/sfpe_top.v
// serial flash page write and region wipe command sequencer
// Operation
// - select stays low for whole command
// - data past page end wraps to start
// - over 256 bytes keeps last 256
// - unsent bytes of page stay unchanged
// - page write needs byte-aligned select release
// - select rise starts timed program or wipe
// - busy flag high during timed cycle
// - write latch cleared before cycle ends
// - locked page is never written
// - 32H writes data on four lanes
// - wipe address aligned to containing region
// - wipe needs release after third address byte
// - locked region is never wiped
`timescale 1ns/1ps
`include "sfpe_consts.vh"
module sfpe_top #(
  parameter [31:0] PROG_CYCLES = `SFPE_PROG_CYCLES,
  parameter [31:0] WIPE_CYCLES = `SFPE_WIPE_CYCLES,
  parameter FIFO_DEPTH = `SFPE_FIFO_DEPTH,
  parameter FIFO_AW = `SFPE_FIFO_AW
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // serial pins
  input wire sclk,
  input wire cs_n,
  input wire [3:0] quad_lanes,
  // status and control
  input wire write_unlock_cmd,
  input wire four_lane_enable_bit,
  input wire region_lock_hit,
  output reg write_latch_flag_reg,
  output reg busy_flag_reg,
  output reg [23:0] lock_query_addr_reg,
  // array wipe port
  output reg wipe_req_reg,
  output reg [23:0] wipe_addr_reg,
  output reg [1:0] wipe_kind_reg,
  // array write port
  output reg mem_wr_valid_reg,
  input wire mem_wr_ready,
  output reg [23:0] mem_wr_addr_reg,
  output reg [7:0] mem_wr_data_reg
);

  localparam P_IDLE = 3'b001;
  localparam P_ACTIVE = 3'b010;
  localparam P_SKIP = 3'b100;
  localparam B_READY = 3'b001;
  localparam B_PROG = 3'b010;
  localparam B_WIPE = 3'b100;

  function is_wipe;
    input [7:0] op;
    begin
      is_wipe = (op == `SFPE_OP_WIPE_S) || (op == `SFPE_OP_WIPE_32) || (op == `SFPE_OP_WIPE_64);
    end
  endfunction

  function is_page;
    input [7:0] op;
    begin
      is_page = (op == `SFPE_OP_PAGE) || (op == `SFPE_OP_PAGE4);
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, a change counts once stages two and three agree
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  reg [5:0] sync3_reg;
  reg [5:0] filt_reg;
  wire [5:0] pins;
  wire [5:0] filt_next;
  genvar g;

  assign pins = {sclk, cs_n, quad_lanes};
  generate
    for (g = 0; g < 6; g = g + 1) begin : sync_bits
      assign filt_next[g] = (sync2_reg[g] == sync3_reg[g]) ? sync3_reg[g] : filt_reg[g];
    end
  endgenerate

  always @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 6'h10;
      sync2_reg <= 6'h10;
      sync3_reg <= 6'h10;
      filt_reg <= 6'h10;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
    end
  end

  wire sclk_rise = filt_next[5] && !filt_reg[5];
  wire cs_fall = !filt_next[4] && filt_reg[4];
  wire cs_rise = filt_next[4] && !filt_reg[4];
  wire [3:0] lanes = filt_next[3:0];

  ////////////////////////////////////////////////////////////////
  // frame decoder
  reg [2:0] phase_reg;
  reg [2:0] bit_cnt_reg;
  reg [2:0] byte_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] opcode_reg;
  reg [23:0] addr_reg;
  reg data_seen_reg;
  reg [2:0] busy_state_reg;
  reg [7:0] page_buf_reg [0:255];
  reg [255:0] mask_reg;
  reg [15:0] page_reg;
  reg [7:0] ptr_reg;

  wire in_data = (byte_cnt_reg == `SFPE_HDR_BYTES);
  wire quad_step = in_data && (opcode_reg == `SFPE_OP_PAGE4);
  wire [7:0] shift_next = quad_step ? {shift_reg[3:0], lanes} : {shift_reg[6:0], lanes[0]};
  wire [2:0] bit_next = bit_cnt_reg + (quad_step ? 3'h4 : 3'h1);
  wire byte_done = (phase_reg == P_ACTIVE) && sclk_rise && (bit_next == 3'h0);
  wire [23:0] addr_next = {addr_reg[15:0], shift_next};
  wire aligned = (bit_cnt_reg == 3'h0);
  // a select release anywhere but a byte boundary drops the frame
  wire wipe_ok = is_wipe(opcode_reg) && in_data && !data_seen_reg && aligned;
  wire page_ok = is_page(opcode_reg) && data_seen_reg && aligned;
  // lock decode has had the time since the third address byte to settle on the queried address
  wire allowed = write_latch_flag_reg && !region_lock_hit;
  wire end_ok = cs_rise && (phase_reg == P_ACTIVE) && allowed;
  wire start_prog = end_ok && page_ok;
  wire start_wipe = end_ok && wipe_ok;

  always @(posedge clk) begin
    if (rst) begin
      phase_reg <= P_IDLE;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h00_0000;
      data_seen_reg <= 1'b0;
      lock_query_addr_reg <= 24'h00_0000;
    end else begin
      case (phase_reg)
        P_IDLE: begin
          if (cs_fall) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 3'h0;
            data_seen_reg <= 1'b0;
            opcode_reg <= 8'h00;
            // frames arriving during a timed cycle are not acted on
            phase_reg <= (busy_state_reg == B_READY) ? P_ACTIVE : P_SKIP;
          end
        end
        P_ACTIVE: begin
          if (cs_rise) begin
            phase_reg <= P_IDLE;
          end else if (sclk_rise) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_next;
            if (byte_done) begin
              if (byte_cnt_reg == 3'h0) begin
                opcode_reg <= shift_next;
                // quad write without four lane enable is not accepted
                if (!(is_page(shift_next) || is_wipe(shift_next)) ||
                    ((shift_next == `SFPE_OP_PAGE4) && !four_lane_enable_bit)) begin
                  phase_reg <= P_SKIP;
                end
              end else if (!in_data) begin
                addr_reg <= addr_next;
                if (byte_cnt_reg == 3'h3) begin
                  lock_query_addr_reg <= addr_next;
                end
              end else begin
                data_seen_reg <= 1'b1;
              end
              if (!in_data) begin
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
              end
            end
          end
        end
        P_SKIP: begin
          if (cs_rise) begin
            phase_reg <= P_IDLE;
          end
        end
        default: begin
          phase_reg <= P_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // page buffer: byte mask marks which addresses the frame supplied
  wire hdr_done = byte_done && (byte_cnt_reg == 3'h3) && is_page(opcode_reg);
  wire data_byte = byte_done && in_data && is_page(opcode_reg);
  reg drain_active_reg;
  reg [7:0] drain_idx_reg;
  wire fifo_in_ready;
  wire fifo_in_valid = drain_active_reg && mask_reg[drain_idx_reg];
  wire drain_step = drain_active_reg && (fifo_in_ready || !mask_reg[drain_idx_reg]);

  always @(posedge clk) begin
    if (data_byte) begin
      page_buf_reg[ptr_reg] <= shift_next;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      mask_reg <= {256{1'b0}};
      page_reg <= 16'h0000;
      ptr_reg <= 8'h00;
    end else if (hdr_done) begin
      mask_reg <= {256{1'b0}};
      page_reg <= addr_next[23:8];
      ptr_reg <= addr_next[7:0];
    end else if (data_byte) begin
      mask_reg[ptr_reg] <= 1'b1;
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////
  // write-out: masked bytes stream through the fifo, stalled by the array
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire fifo_out_ready = !mem_wr_valid_reg || mem_wr_ready;

  sfpe_fifo #(
    .WIDTH(`SFPE_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({page_reg, drain_idx_reg, page_buf_reg[drain_idx_reg]}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always @(posedge clk) begin
    if (rst) begin
      drain_active_reg <= 1'b0;
      drain_idx_reg <= 8'h00;
      mem_wr_valid_reg <= 1'b0;
      mem_wr_addr_reg <= 24'h00_0000;
      mem_wr_data_reg <= 8'h00;
    end else begin
      if (start_prog) begin
        drain_active_reg <= 1'b1;
        drain_idx_reg <= 8'h00;
      end else if (drain_step) begin
        drain_idx_reg <= drain_idx_reg + 8'h01;
        if (drain_idx_reg == 8'hff) begin
          drain_active_reg <= 1'b0;
        end
      end
      if (fifo_out_ready) begin
        mem_wr_valid_reg <= fifo_out_valid;
        if (fifo_out_valid) begin
          mem_wr_addr_reg <= fifo_out_data[31:8];
          mem_wr_data_reg <= fifo_out_data[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // self-timed cycle, busy flag and write latch
  reg [31:0] timer_reg;
  wire write_out_idle = !drain_active_reg && !fifo_out_valid && !mem_wr_valid_reg;
  reg [23:0] wipe_base;
  reg [1:0] wipe_kind;

  always @* begin
    wipe_base = addr_reg;
    wipe_kind = `SFPE_KIND_SECTOR;
    if (opcode_reg == `SFPE_OP_WIPE_64) begin
      wipe_base[`SFPE_BLK64_BITS-1:0] = {`SFPE_BLK64_BITS{1'b0}};
      wipe_kind = `SFPE_KIND_BLK64;
    end else if (opcode_reg == `SFPE_OP_WIPE_32) begin
      wipe_base[`SFPE_BLK32_BITS-1:0] = {`SFPE_BLK32_BITS{1'b0}};
      wipe_kind = `SFPE_KIND_BLK32;
    end else begin
      wipe_base[`SFPE_SECTOR_BITS-1:0] = {`SFPE_SECTOR_BITS{1'b0}};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      busy_state_reg <= B_READY;
      busy_flag_reg <= 1'b0;
      timer_reg <= 32'h0000_0000;
      wipe_req_reg <= 1'b0;
      wipe_addr_reg <= 24'h00_0000;
      wipe_kind_reg <= `SFPE_KIND_SECTOR;
    end else begin
      wipe_req_reg <= 1'b0;
      case (busy_state_reg)
        B_READY: begin
          if (start_prog) begin
            busy_state_reg <= B_PROG;
            busy_flag_reg <= 1'b1;
            timer_reg <= PROG_CYCLES;
          end else if (start_wipe) begin
            busy_state_reg <= B_WIPE;
            busy_flag_reg <= 1'b1;
            timer_reg <= WIPE_CYCLES;
            wipe_req_reg <= 1'b1;
            wipe_addr_reg <= wipe_base;
            wipe_kind_reg <= wipe_kind;
          end
        end
        B_PROG: begin
          if (timer_reg > 32'h0000_0001) begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end else if (write_out_idle) begin
            // busy holds until the array has taken every byte
            busy_state_reg <= B_READY;
            busy_flag_reg <= 1'b0;
            timer_reg <= 32'h0000_0000;
          end
        end
        B_WIPE: begin
          if (timer_reg > 32'h0000_0001) begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end else begin
            busy_state_reg <= B_READY;
            busy_flag_reg <= 1'b0;
            timer_reg <= 32'h0000_0000;
          end
        end
        default: begin
          busy_state_reg <= B_READY;
          busy_flag_reg <= 1'b0;
        end
      endcase
    end
  end

  // latch drops as the cycle starts; a new unlock in the same cycle wins
  always @(posedge clk) begin
    if (rst) begin
      write_latch_flag_reg <= 1'b0;
    end else if (write_unlock_cmd) begin
      write_latch_flag_reg <= 1'b1;
    end else if (start_prog || start_wipe) begin
      write_latch_flag_reg <= 1'b0;
    end
  end

endmodule

// File: rtl/sfpe_consts.vh
// constants for the serial flash page write and wipe sequencer
`ifndef SFPE_CONSTS_VH
`define SFPE_CONSTS_VH
// opcodes
`define SFPE_OP_PAGE 8'h02
`define SFPE_OP_PAGE4 8'h32
`define SFPE_OP_WIPE_S 8'h20
`define SFPE_OP_WIPE_32 8'h52
`define SFPE_OP_WIPE_64 8'hd8
// frame layout: opcode byte plus three address bytes
`define SFPE_HDR_BYTES 3'h4
// region sizes as address bit counts
`define SFPE_PAGE_BITS 8
`define SFPE_SECTOR_BITS 12
`define SFPE_BLK32_BITS 15
`define SFPE_BLK64_BITS 16
// wipe kind codes
`define SFPE_KIND_SECTOR 2'h0
`define SFPE_KIND_BLK32 2'h1
`define SFPE_KIND_BLK64 2'h2
// timing
`define SFPE_CLK_PERIOD_NS 50
`define SFPE_PROG_TIME_US 1000
`define SFPE_WIPE_TIME_US 50000
`define SFPE_PROG_CYCLES ((`SFPE_PROG_TIME_US * 1000) / `SFPE_CLK_PERIOD_NS)
`define SFPE_WIPE_CYCLES ((`SFPE_WIPE_TIME_US * 1000) / `SFPE_CLK_PERIOD_NS)
// write-out buffer
`define SFPE_FIFO_WIDTH 32
`define SFPE_FIFO_DEPTH 16
`define SFPE_FIFO_AW 4
`endif

// File: rtl/sfpe_fifo.v
// synchronous fifo between the page buffer and the array write port
`timescale 1ns/1ps
module sfpe_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  ////////////////////////////////////////////////////////////////
  // depth must be a power of two so the pointers wrap by themselves
  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// File: sim/sfpe_props.sv
// assertions on the sequencer's ports
`timescale 1ns/1ps
module sfpe_props #(
  parameter [31:0] PROG_CYCLES = 32'h0000_0032
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // pins and status
  input wire cs_n,
  input wire region_lock_hit,
  input wire write_latch_flag_reg,
  input wire busy_flag_reg,
  // array ports
  input wire wipe_req_reg,
  input wire [23:0] wipe_addr_reg,
  input wire [1:0] wipe_kind_reg,
  input wire mem_wr_valid_reg,
  input wire mem_wr_ready,
  input wire [23:0] mem_wr_addr_reg,
  input wire [7:0] mem_wr_data_reg
);
  reg [31:0] busy_cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a cut-short timed cycle only shows as a low count at the fall
  always @(posedge clk) begin
    busy_cnt_reg <= (rst || !busy_flag_reg) ? 32'h0000_0000 : busy_cnt_reg + 32'h0000_0001;
  end
  sequence s_start;
    !busy_flag_reg ##1 busy_flag_reg;
  endsequence
  sequence s_wipe;
    wipe_req_reg ##1 !wipe_req_reg;
  endsequence
  AST_BUSY_HOLD: assert property (s_start |-> busy_flag_reg [*8]) else $error("busy short");
  AST_START_REL: assert property (s_start |-> cs_n && $past(cs_n, 2)) else $error("start in frame");
  AST_LATCH_CLR: assert property (s_start |-> ##[0:2] !write_latch_flag_reg) else $error("latch kept");
  AST_LATCH_REQ: assert property (s_start |-> $past(write_latch_flag_reg, 2)) else $error("no latch");
  AST_WIPE_PULSE: assert property (wipe_req_reg |-> s_wipe) else $error("wipe pulse");
  AST_WIPE_BUSY: assert property (wipe_req_reg |-> ##[0:1] busy_flag_reg) else $error("wipe idle");
  AST_WIPE_LOCK: assert property (wipe_req_reg |-> !region_lock_hit) else $error("locked wipe");
  AST_WIPE_ALIGN: assert property (wipe_req_reg |->
    (wipe_kind_reg == 2'h0 && wipe_addr_reg[11:0] == 12'h000) ||
    (wipe_kind_reg == 2'h1 && wipe_addr_reg[14:0] == 15'h0000) ||
    (wipe_kind_reg == 2'h2 && wipe_addr_reg[15:0] == 16'h0000)) else $error("wipe base");
  AST_WR_HOLD: assert property (mem_wr_valid_reg && !mem_wr_ready |=> mem_wr_valid_reg &&
    $stable(mem_wr_addr_reg) && $stable(mem_wr_data_reg)) else $error("write dropped");
  AST_WR_BUSY: assert property (mem_wr_valid_reg |-> busy_flag_reg) else $error("write idle");
  AST_MIN_TIME: assert property ($fell(busy_flag_reg) |->
    busy_cnt_reg >= PROG_CYCLES - 32'h0000_0002) else $error("cycle short");
endmodule
bind sfpe_top sfpe_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.clk, .rst, .cs_n, .region_lock_hit,
  .write_latch_flag_reg, .busy_flag_reg, .wipe_req_reg, .wipe_addr_reg, .wipe_kind_reg,
  .mem_wr_valid_reg, .mem_wr_ready, .mem_wr_addr_reg, .mem_wr_data_reg);

// File: sim/sfpe_host.sv
// host controller model driving the serial pins
`timescale 1ns/1ps
module sfpe_host (
  // clock
  input wire clk,
  // serial pins
  output reg sclk,
  output reg cs_n,
  output reg [3:0] quad_lanes
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    quad_lanes = 4'h0;
  end
  function [7:0] dat(input integer i);
    dat = i[7:0] + (i[8] ? 8'h55 : 8'h00);
  endfunction
  task hold(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // 4 clk half period makes the 400 ns serial clock; idle lanes keep toggling
  task shift(input [7:0] b, input integer n, input quad);
    integer i;
    begin
      for (i = 7; i > 7 - n; i = i - (quad ? 4 : 1)) begin
        quad_lanes <= quad ? b[i -: 4] : {~quad_lanes[3:1], b[i]};
        hold(4);
        sclk <= 1'b1;
        hold(4);
        sclk <= 1'b0;
      end
    end
  endtask
  // cut drops bits from the last byte so the release misses the boundary
  task frame(input [7:0] op, input [23:0] a, input integer n, input quad, input integer cut);
    integer i;
    begin
      @(posedge clk);
      cs_n <= 1'b0;
      hold(4);
      shift(op, 8, 1'b0);
      for (i = 0; i < 3; i = i + 1) begin
        shift(a[23 - 8 * i -: 8], (n == 0 && i == 2) ? 8 - cut : 8, 1'b0);
      end
      for (i = 0; i < n; i = i + 1) begin
        shift(dat(i), (i == n - 1) ? 8 - cut : 8, quad);
      end
      hold(4);
      cs_n <= 1'b1;
      quad_lanes <= ~quad_lanes;
      hold(8);
    end
  endtask
endmodule

// File: sim/test_serial_flash_program_erase.sv
// self-checking bench for the program and wipe sequencer
`timescale 1ns/1ps
module test_serial_flash_program_erase;
  reg clk, rst, write_unlock_cmd, four_lane_enable_bit, region_lock_hit, mem_wr_ready, busy_d, lock_en;
  wire sclk, cs_n, write_latch_flag_reg, busy_flag_reg, wipe_req_reg, mem_wr_valid_reg;
  wire [3:0] quad_lanes;
  wire [23:0] lock_query_addr_reg, wipe_addr_reg, mem_wr_addr_reg;
  wire [1:0] wipe_kind_reg;
  wire [7:0] mem_wr_data_reg;
  integer num_errors, samples_checked, cycles, busy_n;
  reg [23:0] last_wa;
  reg [1:0] last_wk;
  logic [31:0] wq[$];
  sfpe_top #(.PROG_CYCLES(32'h0000_0032), .WIPE_CYCLES(32'h0000_0050)) DUT (.clk, .rst, .sclk, .cs_n,
    .quad_lanes, .write_unlock_cmd, .four_lane_enable_bit, .region_lock_hit, .write_latch_flag_reg,
    .busy_flag_reg, .lock_query_addr_reg, .wipe_req_reg, .wipe_addr_reg, .wipe_kind_reg,
    .mem_wr_valid_reg, .mem_wr_ready, .mem_wr_addr_reg, .mem_wr_data_reg);
  sfpe_host host (.clk, .sclk, .cs_n, .quad_lanes);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////
  task check(input [31:0] seen, input [31:0] exp, input string what);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // the monitor samples on the edge so no process order matters
  always @(posedge clk) begin
    cycles <= cycles + 1;
    busy_d <= busy_flag_reg;
    // lock decoder model: only the 4KB sector at 00_1000 is locked while lock_en is high
    region_lock_hit <= lock_en && (lock_query_addr_reg[23:12] == 12'h001);
    if (busy_flag_reg === 1'b1 && busy_d !== 1'b1) begin
      busy_n <= busy_n + 1;
    end
    if (wipe_req_reg === 1'b1) begin
      last_wa <= wipe_addr_reg;
      last_wk <= wipe_kind_reg;
    end
    if (mem_wr_valid_reg === 1'b1 && mem_wr_ready === 1'b1) begin
      wq.push_back({mem_wr_addr_reg, mem_wr_data_reg});
    end
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  task unlock;
    write_unlock_cmd <= 1'b1;
    @(posedge clk);
    write_unlock_cmd <= 1'b0;
  endtask
  task wait_busy(input val, input integer lim);
    integer n;
    begin
      n = 0;
      while (busy_flag_reg !== val && n < lim) begin
        @(posedge clk);
        n = n + 1;
      end
      host.hold(2);
      check(busy_flag_reg, val, "busy");
    end
  endtask
  task refused(input [7:0] op, input integer n, input quad, input integer cut);
    integer b;
    begin
      b = busy_n;
      host.frame(op, 24'h00_1234, n, quad, cut);
      host.hold(20);
      check(busy_n, b, "refused");
    end
  endtask
  ////////////////////////////////////////
  task t_refuse;
    refused(8'h20, 0, 1'b0, 0);
    unlock;
    refused(8'h52, 0, 1'b0, 1);
    refused(8'h02, 2, 1'b0, 3);
    refused(8'h32, 1, 1'b1, 0);
    lock_en <= 1'b1;
    refused(8'hd8, 0, 1'b0, 0);
    check(lock_query_addr_reg, 24'h00_1234, "query");
    refused(8'h02, 1, 1'b0, 0);
    lock_en <= 1'b0;
    check(write_latch_flag_reg, 1'b1, "latch");
    $display("refusals done");
  endtask
  task t_wipes;
    integer k;
    for (k = 0; k < 3; k = k + 1) begin
      unlock;
      host.frame(k == 0 ? 8'h20 : k == 1 ? 8'h52 : 8'hd8, 24'h0a_bcde, 0, 1'b0, 0);
      wait_busy(1'b1, 20);
      check(last_wk, k, "kind");
      check(lock_query_addr_reg, 24'h0a_bcde, "query");
      check(last_wa, 24'h0a_bcde & (k == 0 ? 24'hff_f000 : k == 1 ? 24'hff_8000 : 24'hff_0000), "base");
      check(write_latch_flag_reg, 1'b0, "latch");
      wait_busy(1'b0, 120);
    end
    $display("wipes done");
  endtask
  task t_page;
    wq.delete();
    unlock;
    host.frame(8'h02, 24'h00_01fe, 3, 1'b0, 0);
    wait_busy(1'b1, 20);
    // busy also covers the full 256-slot drain of the page buffer
    wait_busy(1'b0, 400);
    check(wq.size(), 3, "count");
    check(wq[0], 32'h0001_0002, "wrap");
    check(wq[1], 32'h0001_fe00, "first");
    check(wq[2], 32'h0001_ff01, "second");
    $display("page done");
  endtask
  task t_over;
    integer k;
    begin
      wq.delete();
      unlock;
      four_lane_enable_bit <= 1'b1;
      mem_wr_ready <= 1'b0;
      host.frame(8'h32, 24'h00_0200, 258, 1'b1, 0);
      wait_busy(1'b1, 20);
      host.hold(300);
      check(busy_flag_reg, 1'b1, "held");
      mem_wr_ready <= 1'b1;
      wait_busy(1'b0, 600);
      check(wq.size(), 256, "count");
      for (k = 0; k < 256; k = k + 1) begin
        check(wq[k], {24'h00_0200 + k[23:0], k < 2 ? k[7:0] + 8'h55 : k[7:0]}, "word");
      end
      $display("quad done");
    end
  endtask
  initial begin
    rst = 1'b1;
    write_unlock_cmd = 1'b0;
    four_lane_enable_bit = 1'b0;
    lock_en = 1'b0;
    mem_wr_ready = 1'b1;
    busy_d = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    busy_n = 0;
    last_wk = 2'h3;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    host.hold(6);
    t_refuse;
    t_wipes;
    t_page;
    t_over;
    finish_test;
  end
endmodule
